// *** rtl/cdv_top.sv ***
// reflectometry result capture and variance control registers
`timescale 1ns/1ps
module cdv_top #(
    parameter int UNIT_TICKS = cdv_pkg::UNIT_TICKS,
    parameter int ERR_W      = 8
) (
    input  wire logic                    clk_i,         // system clock
    input  wire logic                    rst_i,         // async reset
    input  wire logic [4:0]              addr_i,        // register address
    input  wire logic [15:0]             wdata_i,       // write data
    input  wire logic                    wr_i,          // write strobe
    input  wire logic                    rd_i,          // read strobe
    output logic      [15:0]             rdata_o,       // read data
    output logic                         pulse_launch_o,// send pulse now
    input  wire logic                    smp_valid_i,   // one 8 ns sample
    input  wire logic [5:0]              smp_i,         // echo sample
    input  wire logic                    sym_valid_i,   // 100 Mb symbol
    input  wire logic signed [ERR_W-1:0] sym_err_i      // symbol error
);

    // ************************************************************
    // declarations
    // ************************************************************
    cdv_pkg::cdv_cap_t state_q;
    logic              pulse_send_q;
    logic              minimum_detect_mode_q;
    logic [5:0]        thr_q;
    logic [7:0]        window_begin_q;
    logic [7:0]        window_end_q;
    logic [7:0]        t_q;
    logic [5:0]        peak_q;
    logic [7:0]        peak_time_index_q;
    logic              peak_seen_q;
    logic              threshold_met_flag_q;
    logic [7:0]        threshold_time_index_q;
    logic              var_en_q;
    logic [1:0]        var_period_q;
    logic              var_frz_q;
    logic              var_rdy_q;
    logic              var_hi_q;
    logic [31:0]       var_data_q;
    logic [31:0]       var_sum;
    logic              var_done;
    logic              var_load;
    logic              var_restart;
    logic              var_rd2;
    logic              wr_rctrl;
    logic              wr_vctrl;
    logic              in_win;
    logic              smp_take;
    logic              better;
    logic              meets;
    logic              cap_done;
    logic [15:0]       rd_d;

    // ************************************************************
    // register decode
    // ************************************************************
    assign wr_rctrl = wr_i && (addr_i == cdv_pkg::A_RCTRL);
    assign wr_vctrl = wr_i && (addr_i == cdv_pkg::A_VCTRL);
    assign var_rd2  = rd_i && (addr_i == cdv_pkg::A_VDATA) && var_hi_q;
    assign var_restart = wr_vctrl
                         && (wdata_i[2:1] != var_period_q);

    // reflect control and window fields
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            minimum_detect_mode_q <= 1'b0;
            thr_q                 <= cdv_pkg::THR_RST;
            window_begin_q        <= cdv_pkg::WIN_RST;
            window_end_q          <= cdv_pkg::WIN_RST;
        end
        else
        begin
            if (wr_rctrl)
            begin
                minimum_detect_mode_q <= wdata_i[cdv_pkg::B_MIN];
                thr_q                 <= wdata_i[5:0];
            end
            if (wr_i && (addr_i == cdv_pkg::A_RWIN))
            begin
                window_begin_q <= wdata_i[15:8];
                window_end_q   <= wdata_i[7:0];
            end
        end
    end

    // ************************************************************
    // reflectometry capture
    // ************************************************************
    assign in_win   = (t_q >= window_begin_q) && (t_q <= window_end_q);
    assign smp_take = (state_q == cdv_pkg::CS_RUN) && smp_valid_i;
    assign cap_done = smp_take
                      && ((t_q == window_end_q) || (t_q == 8'hff));
    // strict compare keeps the first occurrence of a peak
    assign better   = !peak_seen_q
                      || (minimum_detect_mode_q ? (smp_i < peak_q)
                                                : (smp_i > peak_q));
    assign meets    = minimum_detect_mode_q ? (smp_i < thr_q)
                                            : (smp_i > thr_q);
    assign pulse_launch_o = (state_q == cdv_pkg::CS_LAUNCH);

    // capture sequencing and self clearing send bit
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q      <= cdv_pkg::CS_IDLE;
            pulse_send_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                cdv_pkg::CS_IDLE:
                begin
                    if (wr_rctrl && wdata_i[cdv_pkg::B_SEND])
                    begin
                        state_q      <= cdv_pkg::CS_LAUNCH;
                        pulse_send_q <= 1'b1;
                    end
                end
                cdv_pkg::CS_LAUNCH:
                begin
                    state_q <= cdv_pkg::CS_RUN;
                end
                cdv_pkg::CS_RUN:
                begin
                    if (cap_done)
                    begin
                        state_q      <= cdv_pkg::CS_IDLE;
                        pulse_send_q <= 1'b0;
                    end
                end
                default:
                begin
                    state_q      <= cdv_pkg::CS_IDLE;
                    pulse_send_q <= 1'b0;
                end
            endcase
        end
    end

    // time index in 8 ns sample steps from launch
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            t_q <= '0;
        end
        else if (state_q == cdv_pkg::CS_LAUNCH)
        begin
            t_q <= '0;
        end
        else if (smp_take && (t_q != 8'hff))
        begin
            t_q <= t_q + 8'h01;
        end
    end

    // peak value and time of first occurrence
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            peak_q            <= '0;
            peak_time_index_q <= '0;
            peak_seen_q       <= 1'b0;
        end
        else if (state_q == cdv_pkg::CS_LAUNCH)
        begin
            peak_q            <= '0;
            peak_time_index_q <= '0;
            peak_seen_q       <= 1'b0;
        end
        else if (smp_take && in_win && better)
        begin
            peak_q            <= smp_i;
            peak_time_index_q <= t_q;
            peak_seen_q       <= 1'b1;
        end
    end

    // threshold flag and time of first hit
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            threshold_met_flag_q   <= 1'b0;
            threshold_time_index_q <= '0;
        end
        else if (state_q == cdv_pkg::CS_LAUNCH)
        begin
            threshold_met_flag_q   <= 1'b0;
            threshold_time_index_q <= '0;
        end
        else if (smp_take && in_win && meets && !threshold_met_flag_q)
        begin
            threshold_met_flag_q   <= 1'b1;
            threshold_time_index_q <= t_q;
        end
    end

    // ************************************************************
    // variance control
    // ************************************************************
    cdv_var_acc #(
        .UNIT_TICKS (UNIT_TICKS),
        .ERR_W      (ERR_W)
    ) u_acc (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .enable_i    (var_en_q),
        .restart_i   (var_restart),
        .period_i    (var_period_q),
        .sym_valid_i (sym_valid_i),
        .sym_err_i   (sym_err_i),
        .sum_o       (var_sum),
        .done_o      (var_done)
    );
    assign var_load = var_done && !var_frz_q;

    // enable, period and freeze bits
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            var_en_q     <= 1'b0;
            var_period_q <= 2'h0;
            var_frz_q    <= 1'b0;
        end
        else if (wr_vctrl)
        begin
            var_en_q     <= wdata_i[cdv_pkg::B_EN];
            var_period_q <= wdata_i[2:1];
            var_frz_q    <= wdata_i[cdv_pkg::B_FRZ];
        end
        else if (var_rd2)
        begin
            var_frz_q    <= 1'b0;
        end
    end

    // ready flag, set wins over clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            var_rdy_q <= 1'b0;
        end
        else if (var_load)
        begin
            var_rdy_q <= 1'b1;
        end
        else if (var_rd2)
        begin
            var_rdy_q <= 1'b0;
        end
    end

    // data register and half select
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            var_data_q <= '0;
            var_hi_q   <= 1'b0;
        end
        else
        begin
            if (var_load)
            begin
                var_data_q <= var_sum;
            end
            if (rd_i || wr_vctrl)
            begin
                var_hi_q <= rd_i && (addr_i == cdv_pkg::A_VDATA) && !var_hi_q;
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb
    begin
        rd_d = '0;
        case (addr_i)
            cdv_pkg::A_RCTRL:
                rd_d = {4'h0, pulse_send_q, 3'h0,
                        minimum_detect_mode_q, 1'b0, thr_q};
            cdv_pkg::A_RWIN: rd_d = {window_begin_q, window_end_q};
            cdv_pkg::A_PEAK:
                rd_d = {2'h0, peak_q, peak_time_index_q};
            cdv_pkg::A_THR:
                rd_d = {7'h00, threshold_met_flag_q,
                        threshold_time_index_q};
            cdv_pkg::A_VCTRL:
                rd_d = {var_rdy_q, 11'h000, var_frz_q,
                        var_period_q, var_en_q};
            cdv_pkg::A_VDATA:
                rd_d = var_hi_q ? var_data_q[31:16]
                                : var_data_q[15:0];
            default:         rd_d = '0;
        endcase
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= '0;
        end
        else
        begin
            rdata_o <= rd_i ? rd_d : 16'h0000;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_send_self_clear: assert property (
        cap_done |=> !pulse_send_q && pulse_launch_o == 1'b0)
        else $error("send bit did not clear after capture");
    a_launch_clears: assert property (
        pulse_launch_o |=> peak_q == 6'h00 && !threshold_met_flag_q
                           && !peak_seen_q)
        else $error("results not cleared at launch");
    a_peak_tracks: assert property (
        smp_take && in_win && !minimum_detect_mode_q && peak_seen_q
        && smp_i > peak_q |=> peak_q == $past(smp_i))
        else $error("peak value missed a larger sample");
    a_peak_time_hold: assert property (
        smp_take && peak_seen_q && smp_i == peak_q
        |=> $stable(peak_time_index_q))
        else $error("peak time moved on an equal sample");
    a_thr_first_hit: assert property (
        smp_take && in_win && meets && !threshold_met_flag_q
        |=> threshold_met_flag_q
            && threshold_time_index_q == $past(t_q))
        else $error("threshold hit not recorded");
    a_rsvd_zero: assert property (
        rd_i && addr_i == cdv_pkg::A_VCTRL
        |=> rdata_o[14:4] == 11'h000 && rdata_o[15] == $past(var_rdy_q))
        else $error("variance control readback wrong");
    a_ready_clear: assert property (
        var_rd2 && !var_load |=> !var_rdy_q && !var_frz_q)
        else $error("ready or freeze survived second read");
    a_freeze_hold: assert property (
        var_frz_q ##1 var_frz_q |-> $stable(var_data_q))
        else $error("variance data changed while frozen");
    a_data_halves: assert property (
        var_rd2 |=> rdata_o == $past(var_data_q[31:16]))
        else $error("second data read not high half");
    a_enable_off: assert property (
        !var_en_q |=> !var_done)
        else $error("variance loaded while disabled");
    c_shot_done: cover property (pulse_launch_o ##[1:300] cap_done);
    c_thr_met: cover property (smp_take && in_win && meets);
    c_var_load: cover property (var_load);
    c_read_pair: cover property (var_rd2 && var_frz_q);

endmodule // cdv_top

// *** rtl/cdv_pkg.sv ***
// constants for cable reflectometry results and variance control
package cdv_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int          ADDR_W      = 5;
    localparam int          DATA_W      = 16;
    localparam logic [4:0]  A_RCTRL     = 5'h16;
    localparam logic [4:0]  A_RWIN      = 5'h17;
    localparam logic [4:0]  A_PEAK      = 5'h18;
    localparam logic [4:0]  A_THR       = 5'h19;
    localparam logic [4:0]  A_VCTRL     = 5'h1a;
    localparam logic [4:0]  A_VDATA     = 5'h1b;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int          B_SEND      = 11;
    localparam int          B_MIN       = 7;
    localparam int          B_MET       = 8;
    localparam int          B_RDY       = 15;
    localparam int          B_FRZ       = 3;
    localparam int          B_EN        = 0;
    localparam logic [5:0]  THR_RST     = 6'h20;
    localparam logic [7:0]  WIN_RST     = 8'h00;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          STEP_NS     = 8;
    localparam int          UNIT_TICKS  = 131072;
    localparam int          UNITS_BASE  = 2;

    // reflectometry capture states, gray from idle to run, both bits fall on the return to idle
    typedef enum logic [1:0] {
        CS_IDLE   = 2'b00,
        CS_LAUNCH = 2'b01,
        CS_RUN    = 2'b11
    } cdv_cap_t;

endpackage

// *** rtl/cdv_var_acc.sv ***
// variance accumulator with selectable period timer
`timescale 1ns/1ps
module cdv_var_acc #(
    parameter int UNIT_TICKS = cdv_pkg::UNIT_TICKS,
    parameter int ERR_W      = 8,
    parameter int TW         = 24
) (
    input  wire logic                    clk_i,       // system clock
    input  wire logic                    rst_i,       // async reset
    input  wire logic                    enable_i,    // run computation
    input  wire logic                    restart_i,   // drop partial sum
    input  wire logic [1:0]              period_i,    // period select
    input  wire logic                    sym_valid_i, // one 8 ns symbol
    input  wire logic signed [ERR_W-1:0] sym_err_i,   // receive error
    output logic      [31:0]             sum_o,       // last full sum
    output logic                         done_o       // period expired
);

    logic [TW-1:0]        limit;
    logic [TW-1:0]        cnt_q;
    logic [31:0]          acc_q;
    logic [2*ERR_W-1:0]   sq;
    logic signed [2*ERR_W-1:0] err_x;
    logic                 last;

    // period length in symbol ticks
    assign limit = TW'(UNIT_TICKS * cdv_pkg::UNITS_BASE
                   * (int'(period_i) + 1));
    // sign extend first so the square keeps all of its bits
    assign err_x = {{ERR_W{sym_err_i[ERR_W-1]}}, sym_err_i};
    assign sq    = $unsigned(err_x * err_x);
    assign last  = sym_valid_i && (cnt_q == limit - TW'(1));

    // period timer and running sum
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= '0;
            acc_q <= '0;
        end
        else if (!enable_i || restart_i)
        begin
            cnt_q <= '0;
            acc_q <= '0;
        end
        else if (last)
        begin
            cnt_q <= '0;
            acc_q <= '0;
        end
        else if (sym_valid_i)
        begin
            cnt_q <= cnt_q + TW'(1);
            acc_q <= acc_q + 32'(sq);
        end
    end

    // finished sum and expiry pulse
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sum_o  <= '0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= enable_i && !restart_i && last;
            if (enable_i && !restart_i && last)
            begin
                sum_o <= acc_q + 32'(sq);
            end
        end
    end

endmodule // cdv_var_acc

// *** tb/cdv_top_bench.sv ***
// self-checking bench for reflectometry results and variance control
`timescale 1ns/1ps
module cdv_top_bench;

    // ************************************************************
    // clock, reset and stimulus signals
    // ************************************************************
    localparam int UT = 16;          // shortened period unit
    logic              clk_i;
    logic              rst_i;
    logic [4:0]        addr_i;
    logic [15:0]       wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [15:0]       rdata_o;
    logic              pulse_launch_o;
    logic              smp_valid_i;
    logic [5:0]        smp_i;
    logic              sym_valid_i;
    logic signed [7:0] sym_err_i;
    int                err_count;
    int                check_count;
    int                cyc;
    int                t0;
    logic [15:0]       v;

    cdv_top #(.UNIT_TICKS(UT), .ERR_W(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pulse_launch_o(pulse_launch_o), .smp_valid_i(smp_valid_i),
        .smp_i(smp_i), .sym_valid_i(sym_valid_i), .sym_err_i(sym_err_i)
    );

    // 20 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // cycle count and hang guard
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count = err_count + 1;
            final_report();
        end
    end

    // ************************************************************
    // access and compare tasks
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // one shot: launch, eight samples, send bit back to zero
    task automatic shot(input logic [15:0] ctl, input logic [47:0] s);
        wr(5'h16, ctl);
        #1 chk({15'h0, pulse_launch_o}, 16'h0001);
        rdc(5'h18, 16'h0000);
        rdc(5'h16, ctl & 16'h08bf);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            smp_valid_i <= 1'b1;
            smp_i       <= s[i*6 +: 6];
        end
        @(posedge clk_i);
        smp_valid_i <= 1'b0;
        rdc(5'h16, ctl & 16'h00bf);
    endtask

    // wait for ready, return cycles since t0
    task automatic wait_rdy(output int t);
        logic [15:0] d;
        d = 16'h0;
        for (int i = 0; i < 200 && d[15] !== 1'b1; i++)
            rd(5'h1a, d);
        t = cyc - t0;
    endtask

    // restart at period p, then freeze and read the sum of unit errors
    task automatic per_run(input logic [1:0] p, input logic [15:0] s);
        int t;
        int n;
        n = 2*(int'(p)+1)*UT;
        wr(5'h1a, {13'h0000, p, 1'b1});
        t0 = cyc;
        wait_rdy(t);
        chk({15'h0, t >= n && t <= n+6}, 16'h0001);
        wr(5'h1a, {12'h000, 1'b1, p, 1'b1});
        rdc(5'h1b, s);
        rdc(5'h1b, 16'h0000);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        int t;
        err_count = 0; check_count = 0; cyc = 0;
        rst_i = 1'b1; addr_i = 5'h0; wdata_i = 16'h0; wr_i = 1'b0;
        rd_i = 1'b0; smp_valid_i = 1'b0; smp_i = 6'h0;
        sym_valid_i = 1'b1; sym_err_i = 8'sh03;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, unmapped and reserved places
        repeat (100) @(posedge clk_i);
        rdc(5'h18, 16'h0000);
        rdc(5'h19, 16'h0000);
        rdc(5'h1a, 16'h0000);
        rdc(5'h16, 16'h0020);
        rdc(5'h05, 16'h0000);
        wr(5'h18, 16'hffff);
        rdc(5'h18, 16'h0000);
        wr(5'h19, 16'hffff);
        rdc(5'h19, 16'h0000);
        wr(5'h1a, 16'h7ff0);
        rdc(5'h1a, 16'h0000);
        $display("test registers done");
        // max mode: window 2..7, early big samples lie outside it
        wr(5'h17, 16'h0207);
        shot(16'h0825, {6'h24, 6'h26, 6'h2a, 6'h2a, 6'h28, 6'h22, 6'h3e,
                        6'h3f});
        rdc(5'h18, 16'h2a04);
        rdc(5'h19, 16'h0103);
        // min mode: nothing below threshold in window
        shot(16'h0890, {6'h30, 6'h1f, 6'h18, 6'h20, 6'h18, 6'h1c, 6'h01,
                        6'h00});
        rdc(5'h18, 16'h1803);
        rdc(5'h19, 16'h0000);
        $display("test reflectometry done");
        // variance, shortest period
        wr(5'h1a, 16'h0001);
        t0 = cyc;
        wait_rdy(t);
        chk({15'h0, t >= 2*UT && t <= 2*UT+6}, 16'h0001);
        wr(5'h1a, 16'h0009);
        sym_err_i <= 8'sh01;
        repeat (5*UT) @(posedge clk_i);
        rdc(5'h1b, 16'h0120);
        rdc(5'h1b, 16'h0000);
        rdc(5'h1a, 16'h0001);
        $display("test variance freeze done");
        // longest period restarts the count
        wr(5'h1a, 16'h0007);
        t0 = cyc;
        rd(5'h1b, v);
        rd(5'h1b, v);
        wait_rdy(t);
        chk({15'h0, t >= 8*UT && t <= 8*UT+6}, 16'h0001);
        wr(5'h1a, 16'h000f);
        rdc(5'h1b, 16'h0080);
        rdc(5'h1b, 16'h0000);
        $display("test variance period done");
        per_run(2'h1, 16'h0040);
        per_run(2'h2, 16'h0060);
        $display("test variance other periods done");
        final_report();
    end

endmodule // cdv_top_bench
